// ===== pkg/tag_framer_pkg.sv
package tag_framer_pkg;

   // ==========================================================
   // Carrier and delimiter timing
   // ==========================================================
   localparam real FC_MHZ       = 13.56;
   localparam real SUB1_DIV     = 32.0;
   localparam real T_GAP_US     = 56.64;
   localparam real T_BIT_US     = 18.88;
   localparam real T_FEOF_HI_US = 37.76;
   localparam real T_FEOF_LO_US = 113.28;

   // Unmodulated times counted in whole carrier/32 periods
   localparam logic [7:0] N_GAP     = 8'(int'(T_GAP_US * FC_MHZ / SUB1_DIV));
   localparam logic [7:0] N_BIT     = 8'(int'(T_BIT_US * FC_MHZ / SUB1_DIV));
   localparam logic [7:0] N_FEOF_HI = 8'(int'(T_FEOF_HI_US * FC_MHZ / SUB1_DIV));
   localparam logic [7:0] N_FEOF_LO = 8'(int'(T_FEOF_LO_US * FC_MHZ / SUB1_DIV));

   // Pulse counts at high rate, standard commands
   localparam logic [7:0] P_LONG = 8'h18;
   localparam logic [7:0] P_BIT  = 8'h08;
   localparam logic [7:0] Q_LONG = 8'h1b;
   localparam logic [7:0] Q_BIT  = 8'h09;
   localparam int         LOW_SH  = 2;
   localparam int         FAST_SH = 1;

   // Carrier cycles per subcarrier period, last index and half
   localparam logic [4:0] DIV1_LAST = 5'h1f;
   localparam logic [4:0] DIV2_LAST = 5'h1b;
   localparam logic [4:0] HALF1     = 5'h10;
   localparam logic [4:0] HALF2     = 5'h0e;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [4:0] A_CTRL  = 5'h00;
   localparam logic [4:0] A_TXD   = 5'h04;
   localparam logic [4:0] A_RXD   = 5'h08;
   localparam logic [4:0] A_AFC   = 5'h0c;
   localparam logic [4:0] A_SFC   = 5'h10;
   localparam logic [4:0] A_UIDL  = 5'h14;
   localparam logic [4:0] A_UIDH  = 5'h18;
   localparam logic [4:0] A_STATE = 5'h1c;

   localparam int CB_TWO    = 0;
   localparam int CB_HIGH   = 1;
   localparam int CB_FAST   = 2;
   localparam int CB_CLR    = 3;
   localparam int CB_START  = 4;
   localparam int CB_FINISH = 5;
   localparam int CB_RXEND  = 6;
   localparam int CB_RXCLR  = 7;
   localparam int SB_BUSY   = 3;
   localparam int SB_ARMED  = 4;
   localparam int SB_RXERR  = 5;
   localparam int SB_UNDER  = 6;
   localparam int SB_HOLD   = 7;
   localparam int SB_STATE  = 8;
   localparam int LOCK_BIT  = 8;

   // ==========================================================
   // CRC
   // ==========================================================
   localparam logic [15:0] CRC_POLY  = 16'h8408;
   localparam logic [15:0] CRC_INIT  = 16'hffff;
   localparam logic [15:0] CRC_RESID = 16'hf0b8;
   localparam logic [1:0]  CRC_NONE  = 2'h0;
   localparam logic [1:0]  CRC_LO    = 2'h1;
   localparam logic [1:0]  CRC_HI    = 2'h2;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [1:0] {
      K_UNMOD = 2'b00,
      K_SUB1  = 2'b01,
      K_SUB2  = 2'b10
   } seg_kind_t;

   typedef enum logic [1:0] {
      P_IDLE = 2'b00,
      P_SOF  = 2'b01,
      P_DATA = 2'b10,
      P_EOF  = 2'b11
   } part_t;

   typedef enum logic [1:0] {
      S_OFF      = 2'b00,
      S_READY    = 2'b01,
      S_QUIET    = 2'b10,
      S_SELECTED = 2'b11
   } tag_state_t;

   typedef struct packed {
      logic fast;
      logic high;
      logic two;
   } cfg_t;

   typedef struct packed {
      seg_kind_t  kind;
      logic [7:0] cnt;
   } seg_t;

   typedef struct packed {
      tag_state_t  tstate;
      cfg_t        cfg;
      part_t       part;
      logic [1:0]  idx;
      seg_t        seg;
      logic [7:0]  left;
      logic [4:0]  cyc;
      logic [7:0]  sh;
      logic [2:0]  bitn;
      logic [7:0]  hold;
      logic        hold_full;
      logic        finish;
      logic [1:0]  crc_ph;
      logic [7:0]  crc_hi;
      logic [15:0] tx_crc;
      logic [15:0] rx_crc;
      logic        armed;
      logic        rx_err;
      logic        under;
      logic [7:0]  afc;
      logic        afc_lock;
      logic [7:0]  sfc;
      logic        sfc_lock;
      logic        mod;
      logic        rd_ack;
      logic [31:0] rdata;
      logic        car1;
      logic        car2;
      logic        car3;
      logic        fld1;
      logic        fld2;
   } framer_state_t;

endpackage

// ===== core/vicinity_tag_response_framer.sv
`timescale 1ns/10ps

// Summary of operation
// (R1) One subcarrier high rate SOF: 56.64us gap, 24 pulses, then logic one.
// (R2) Fast high rate SOF: 28.32us gap, 12 pulses, 9.44us gap, 4 pulses.
// (R3) One subcarrier low rate SOF: 226.56us gap, 96 pulses, logic one.
// (R4) Fast low rate SOF: 113.28us gap, 48 pulses, 37.76us gap, 16 pulses.
// (R5) Two subcarrier high SOF: 27 q, 24 p, 9 q, 8 p; never fast.
// (R6) Two subcarrier low SOF: 108 q, 96 p, 36 q, 32 p.
// (R7) One subcarrier high EOF: logic zero, 24 pulses, 56.64us gap.
// (R8) Fast high EOF: 4 pulses, 9.44us gap, 12 pulses, 37.76us gap.
// (R9) One subcarrier low EOF: 32 pulses, 75.52us, 96 pulses, 226.56us.
// (R10) Fast low EOF: 16 pulses, 37.76us, 48 pulses, 113.28us gap.
// (R11) Two subcarrier high EOF: 8 p, 9 q, 24 p, 27 q.
// (R12) Two subcarrier low EOF: 32 p, 36 q, 96 p, 108 q.
// (R13) Read-only 64-bit identifier: class, maker code, 48-bit serial.
// (R14) Family code nibbles; writes refused once locked.
// (R15) CRC-16 preset ones over frame bytes, appended before EOF.
// (R16) Request with bad CRC is dropped, no response.
// (R17) Low byte first, each byte least significant bit first.
// (R18) No transmission before a correctly received request.
// (R19) Frames carry whole bytes only.
// (R20) Response: SOF, flags, parameters, data, two-byte CRC, EOF.
// (R21) Optional fields present only when their flag is one.
// (R22) Reader should check response CRC, handling is its own.
// (R23) Four protocol states; power-off whenever field is too weak.
// (R24) Data bit: zero is pulses then gap, one is the reverse.
// (R25) Reader picks one or two subcarriers; response follows.
// (R26) Fast commands answer at double the selected rate.
// (R27) All timing counted in carrier cycles, divide by 32 and 28.
// (R28) Delimiter variant from latched subcarrier, rate and fast.
module vicinity_tag_response_framer #(
   parameter logic [7:0]  ALLOC_CLASS = 8'h5a,            // Arbitrary value
   parameter logic [7:0]  MAKER_CODE  = 8'h3c,            // Arbitrary value
   parameter logic [47:0] SERIAL_NUM  = 48'h0123_4567_89ab // Arbitrary value
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   input  wire logic        carrier_in,
   input  wire logic        field_ok_in,
   output logic             load_mod,
   output logic             tx_active
);

   // (R13) fixed identifier
   localparam logic [63:0] UNIQUE_IDENTIFIER = {ALLOC_CLASS, MAKER_CODE, SERIAL_NUM};

   tag_framer_pkg::framer_state_t s_r;
   tag_framer_pkg::framer_state_t s_nxt;
   logic                          car_edge;
   logic                          wr_ok;
   logic                          rd_go;
   logic                          seg_end;
   logic                          need_byte;
   logic [4:0]                    last;
   logic [31:0]                   rd;

   // ==========================================================
   // CRC over one byte, reflected, LSB first
   // ==========================================================
   function automatic logic [15:0] crc_byte(
      input logic [15:0] c,
      input logic [7:0]  d
   );
      logic [15:0] r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ tag_framer_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   // ==========================================================
   // Segment table: kind and period count of one piece
   // ==========================================================
   function automatic tag_framer_pkg::seg_t seg_pick(
      input tag_framer_pkg::part_t part,
      input logic [1:0]            idx,
      input logic                  bitv,
      input tag_framer_pkg::cfg_t  c
   );
      tag_framer_pkg::seg_t      s;
      tag_framer_pkg::seg_kind_t other;
      logic [7:0]                base;
      logic [7:0]                t;
      logic                      sub1;
      logic                      longp;
      logic                      scale;
      // (R25) second subcarrier or gap
      other = c.two ? tag_framer_pkg::K_SUB2 : tag_framer_pkg::K_UNMOD;
      scale = 1'b1;
      unique case (part)
         // (R1) SOF piece order
         // (R5) two subcarrier SOF
         tag_framer_pkg::P_SOF: begin
            sub1  = idx[0];
            longp = ~idx[1];
         end
         // (R7) EOF piece order
         // (R11) two subcarrier EOF
         tag_framer_pkg::P_EOF: begin
            sub1  = ~idx[0];
            longp = idx[1];
         end
         // (R24) Manchester data bit
         default: begin
            sub1  = (idx[0] == bitv);
            longp = 1'b0;
         end
      endcase
      if (sub1) begin
         base = longp ? tag_framer_pkg::P_LONG : tag_framer_pkg::P_BIT;
      end else if (c.two) begin
         base = longp ? tag_framer_pkg::Q_LONG : tag_framer_pkg::Q_BIT;
      end else begin
         base = longp ? tag_framer_pkg::N_GAP : tag_framer_pkg::N_BIT;
      end
      // Fast EOF tail does not follow the common scaling
      // (R8) fast high tail
      // (R10) fast low tail
      if (part == tag_framer_pkg::P_EOF && idx == 2'b11 && c.fast) begin
         base  = c.high ? tag_framer_pkg::N_FEOF_HI : tag_framer_pkg::N_FEOF_LO;
         scale = 1'b0;
      end
      // (R3) low rate times four
      // (R6) low two subcarrier
      // (R9) low EOF
      // (R12) low two subcarrier EOF
      t = (c.high || !scale) ? base : (base << tag_framer_pkg::LOW_SH);
      // (R2) fast halves
      // (R4) fast low halves
      // (R26) doubled rate
      if (c.fast && scale) begin
         t = t >> tag_framer_pkg::FAST_SH;
      end
      s.kind = sub1 ? tag_framer_pkg::K_SUB1 : other;
      s.cnt  = t;
      return s;
   endfunction

   // ==========================================================
   // Bus handshake
   // ==========================================================
   // Reads take one wait cycle so that readdata comes from a flop
   assign waitrequest = (read & ~s_r.rd_ack)
                      | (write & (address == tag_framer_pkg::A_TXD) & s_r.hold_full
                         & (s_r.part != tag_framer_pkg::P_IDLE));
   assign readdata  = s_r.rdata;
   assign load_mod  = s_r.mod;
   assign tx_active = (s_r.part != tag_framer_pkg::P_IDLE);

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      s_nxt     = s_r;
      seg_end   = 1'b0;
      need_byte = 1'b0;
      rd        = '0;
      wr_ok     = write & ~waitrequest;
      rd_go     = read & ~s_r.rd_ack;
      // (R27) carrier edge from the synchroniser
      car_edge  = s_r.car2 & ~s_r.car3;
      last      = (s_r.seg.kind == tag_framer_pkg::K_SUB2) ?
                  tag_framer_pkg::DIV2_LAST : tag_framer_pkg::DIV1_LAST;

      s_nxt.car1 = carrier_in;
      s_nxt.car2 = s_r.car1;
      s_nxt.car3 = s_r.car2;
      s_nxt.fld1 = field_ok_in;
      s_nxt.fld2 = s_r.fld1;

      // ------------------------------------------------------
      // Register writes
      // ------------------------------------------------------
      if (wr_ok) begin
         case (address)
            tag_framer_pkg::A_CTRL: begin
               if (writedata[tag_framer_pkg::CB_CLR]) begin
                  s_nxt.rx_err = 1'b0;
                  s_nxt.under  = 1'b0;
               end
               if (writedata[tag_framer_pkg::CB_RXCLR]) begin
                  s_nxt.rx_crc = tag_framer_pkg::CRC_INIT;
                  s_nxt.armed  = 1'b0;
               end
               if (writedata[tag_framer_pkg::CB_RXEND]) begin
                  // (R16) bad CRC leaves no response armed
                  if (s_nxt.rx_crc == tag_framer_pkg::CRC_RESID) begin
                     s_nxt.armed = 1'b1;
                  end else begin
                     s_nxt.rx_err = 1'b1;
                     s_nxt.armed  = 1'b0;
                  end
               end
               if (writedata[tag_framer_pkg::CB_FINISH] &&
                   s_r.part != tag_framer_pkg::P_IDLE) begin
                  s_nxt.finish = 1'b1;
               end
               // (R18) start only after a good request
               if (writedata[tag_framer_pkg::CB_START] && s_nxt.armed &&
                   s_r.part == tag_framer_pkg::P_IDLE &&
                   s_r.tstate != tag_framer_pkg::S_OFF) begin
                  // (R28) latch variant settings
                  s_nxt.cfg.fast = writedata[tag_framer_pkg::CB_FAST];
                  s_nxt.cfg.high = writedata[tag_framer_pkg::CB_HIGH];
                  // (R5) fast forces one subcarrier
                  s_nxt.cfg.two  = writedata[tag_framer_pkg::CB_TWO] &
                                   ~writedata[tag_framer_pkg::CB_FAST];
                  s_nxt.part   = tag_framer_pkg::P_SOF;
                  s_nxt.idx    = 2'b00;
                  s_nxt.armed  = 1'b0;
                  s_nxt.finish = 1'b0;
                  s_nxt.crc_ph = tag_framer_pkg::CRC_NONE;
                  // (R15) preset all ones
                  s_nxt.tx_crc = tag_framer_pkg::CRC_INIT;
                  s_nxt.seg    = seg_pick(tag_framer_pkg::P_SOF, 2'b00, 1'b0, s_nxt.cfg);
                  s_nxt.left   = s_nxt.seg.cnt;
                  s_nxt.cyc    = '0;
               end
            end
            // (R21) caller supplies only flagged fields
            tag_framer_pkg::A_TXD: begin
               s_nxt.hold      = writedata[7:0];
               s_nxt.hold_full = 1'b1;
            end
            // (R15) receive CRC check
            tag_framer_pkg::A_RXD: begin
               s_nxt.rx_crc = crc_byte(s_nxt.rx_crc, writedata[7:0]);
            end
            // (R14) locked code refuses writes
            tag_framer_pkg::A_AFC: begin
               if (!s_r.afc_lock) begin
                  s_nxt.afc      = writedata[7:0];
                  s_nxt.afc_lock = writedata[tag_framer_pkg::LOCK_BIT];
               end
            end
            tag_framer_pkg::A_SFC: begin
               if (!s_r.sfc_lock) begin
                  s_nxt.sfc      = writedata[7:0];
                  s_nxt.sfc_lock = writedata[tag_framer_pkg::LOCK_BIT];
               end
            end
            tag_framer_pkg::A_STATE: begin
               if (s_r.tstate != tag_framer_pkg::S_OFF &&
                   writedata[1:0] != tag_framer_pkg::S_OFF) begin
                  s_nxt.tstate = tag_framer_pkg::tag_state_t'(writedata[1:0]);
               end
            end
            default: begin
            end
         endcase
      end

      // ------------------------------------------------------
      // Carrier period counter
      // ------------------------------------------------------
      // (R27) divide carrier by 32 or 28
      if (car_edge && s_r.part != tag_framer_pkg::P_IDLE) begin
         if (s_r.cyc == last) begin
            s_nxt.cyc = '0;
            if (s_r.left == 8'h01) begin
               seg_end = 1'b1;
            end else begin
               s_nxt.left = s_r.left - 8'h01;
            end
         end else begin
            s_nxt.cyc = s_r.cyc + 5'h01;
         end
      end

      // ------------------------------------------------------
      // Frame sequencing
      // ------------------------------------------------------
      if (seg_end) begin
         unique case (s_r.part)
            tag_framer_pkg::P_SOF: begin
               if (s_r.idx == 2'b11) begin
                  s_nxt.part = tag_framer_pkg::P_DATA;
                  s_nxt.idx  = 2'b00;
                  need_byte  = 1'b1;
               end else begin
                  s_nxt.idx = s_r.idx + 2'b01;
               end
            end
            tag_framer_pkg::P_DATA: begin
               if (s_r.idx == 2'b00) begin
                  s_nxt.idx = 2'b01;
               end else begin
                  s_nxt.idx = 2'b00;
                  // (R19) whole bytes only
                  if (s_r.bitn == 3'h7) begin
                     need_byte = 1'b1;
                  end else begin
                     s_nxt.bitn = s_r.bitn + 3'h1;
                     // (R17) LSB first
                     s_nxt.sh   = s_r.sh >> 1;
                  end
               end
            end
            tag_framer_pkg::P_EOF: begin
               if (s_r.idx == 2'b11) begin
                  s_nxt.part = tag_framer_pkg::P_IDLE;
               end else begin
                  s_nxt.idx = s_r.idx + 2'b01;
               end
            end
            tag_framer_pkg::P_IDLE: begin
            end
         endcase
      end

      if (need_byte) begin
         s_nxt.bitn = '0;
         // (R20) CRC low, CRC high, then EOF
         if (s_r.crc_ph == tag_framer_pkg::CRC_LO) begin
            s_nxt.sh     = s_r.crc_hi;
            s_nxt.crc_ph = tag_framer_pkg::CRC_HI;
         end else if (s_r.crc_ph == tag_framer_pkg::CRC_HI) begin
            s_nxt.part   = tag_framer_pkg::P_EOF;
            s_nxt.idx    = 2'b00;
            s_nxt.crc_ph = tag_framer_pkg::CRC_NONE;
         end else if (s_nxt.hold_full) begin
            s_nxt.sh        = s_nxt.hold;
            s_nxt.hold_full = 1'b0;
            // (R15) CRC over payload bytes
            s_nxt.tx_crc    = crc_byte(s_r.tx_crc, s_nxt.hold);
         end else begin
            // A missing byte cannot be waited for mid-frame, so close it
            if (!s_nxt.finish) begin
               s_nxt.under = 1'b1;
            end
            // (R17) CRC low byte first
            s_nxt.sh     = ~s_r.tx_crc[7:0];
            s_nxt.crc_hi = ~s_r.tx_crc[15:8];
            s_nxt.crc_ph = tag_framer_pkg::CRC_LO;
            s_nxt.finish = 1'b0;
         end
      end

      if (seg_end && s_nxt.part != tag_framer_pkg::P_IDLE) begin
         s_nxt.seg  = seg_pick(s_nxt.part, s_nxt.idx, s_nxt.sh[0], s_r.cfg);
         s_nxt.left = s_nxt.seg.cnt;
         s_nxt.cyc  = '0;
      end

      // ------------------------------------------------------
      // Field loss
      // ------------------------------------------------------
      // (R23) weak field forces power-off
      if (!s_r.fld2) begin
         s_nxt.tstate    = tag_framer_pkg::S_OFF;
         s_nxt.part      = tag_framer_pkg::P_IDLE;
         s_nxt.armed     = 1'b0;
         s_nxt.hold_full = 1'b0;
         s_nxt.finish    = 1'b0;
         s_nxt.crc_ph    = tag_framer_pkg::CRC_NONE;
      end else if (s_r.tstate == tag_framer_pkg::S_OFF) begin
         s_nxt.tstate = tag_framer_pkg::S_READY;
      end

      // (R27) pulse is high for first half period
      s_nxt.mod = (s_nxt.part != tag_framer_pkg::P_IDLE) &&
                  (s_nxt.seg.kind != tag_framer_pkg::K_UNMOD) &&
                  (s_nxt.cyc < ((s_nxt.seg.kind == tag_framer_pkg::K_SUB2) ?
                                tag_framer_pkg::HALF2 : tag_framer_pkg::HALF1));

      // ------------------------------------------------------
      // Register reads
      // ------------------------------------------------------
      case (address)
         tag_framer_pkg::A_CTRL: begin
            rd[tag_framer_pkg::CB_TWO]   = s_r.cfg.two;
            rd[tag_framer_pkg::CB_HIGH]  = s_r.cfg.high;
            rd[tag_framer_pkg::CB_FAST]  = s_r.cfg.fast;
            rd[tag_framer_pkg::SB_BUSY]  = (s_r.part != tag_framer_pkg::P_IDLE);
            rd[tag_framer_pkg::SB_ARMED] = s_r.armed;
            rd[tag_framer_pkg::SB_RXERR] = s_r.rx_err;
            rd[tag_framer_pkg::SB_UNDER] = s_r.under;
            rd[tag_framer_pkg::SB_HOLD]  = s_r.hold_full;
            rd[tag_framer_pkg::SB_STATE +: 2] = s_r.tstate;
         end
         tag_framer_pkg::A_AFC: begin
            rd[7:0] = s_r.afc;
            rd[tag_framer_pkg::LOCK_BIT] = s_r.afc_lock;
         end
         tag_framer_pkg::A_SFC: begin
            rd[7:0] = s_r.sfc;
            rd[tag_framer_pkg::LOCK_BIT] = s_r.sfc_lock;
         end
         tag_framer_pkg::A_UIDL: begin
            rd = UNIQUE_IDENTIFIER[31:0];
         end
         tag_framer_pkg::A_UIDH: begin
            rd = UNIQUE_IDENTIFIER[63:32];
         end
         tag_framer_pkg::A_STATE: begin
            rd[1:0] = s_r.tstate;
         end
         default: begin
         end
      endcase
      if (rd_go) begin
         s_nxt.rdata = rd;
      end
      s_nxt.rd_ack = rd_go;
   end

   // ==========================================================
   // State register
   // ==========================================================
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_r        <= '0;
         s_r.rx_crc <= tag_framer_pkg::CRC_INIT;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule

// ===== verif/tag_framer_monitor.sv
`timescale 1ns/10ps
module tag_framer_monitor #(
   parameter logic [7:0]  ALLOC_CLASS = 8'h5a,
   parameter logic [7:0]  MAKER_CODE  = 8'h3c,
   parameter logic [47:0] SERIAL_NUM  = 48'h0
) (
   input logic        clk,
   input logic        resetn,
   input logic [4:0]  address,
   input logic        read,
   input logic        write,
   input logic [31:0] writedata,
   input logic [31:0] readdata,
   input logic        waitrequest,
   input logic        field_ok_in,
   input logic        load_mod,
   input logic        tx_active
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence rd_take;
      read && !waitrequest;
   endsequence
   // ==========
   // Bus and link checks
   a_read_stall: assert property ($rose(read) |-> waitrequest ##1 !waitrequest)
      else $error("read not answered on second cycle");
   a_write_fast: assert property (write && address != tag_framer_pkg::A_TXD |-> !waitrequest)
      else $error("write stalled");
   a_rdata_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
      else $error("read data changed without a read");
   a_uid_high: assert property (rd_take ##0 address == tag_framer_pkg::A_UIDH |->
      readdata == {ALLOC_CLASS, MAKER_CODE, SERIAL_NUM[47:32]}) else $error("identifier wrong");
   a_field_off: assert property (!field_ok_in [*5] |-> !load_mod && !tx_active)
      else $error("active without field");
   a_start_cause: assert property ($rose(tx_active) |-> $past(write) &&
      $past(address) == tag_framer_pkg::A_CTRL && $past(writedata[4])) else $error("unasked frame");
   a_mod_frame: assert property (load_mod |-> tx_active)
      else $error("modulation outside frame");
   a_pulse_high: assert property ($rose(load_mod) |-> load_mod [*8])
      else $error("pulse too short");
endmodule
bind vicinity_tag_response_framer tag_framer_monitor #(.ALLOC_CLASS(ALLOC_CLASS),
   .MAKER_CODE(MAKER_CODE), .SERIAL_NUM(SERIAL_NUM)) mon (.clk(clk), .resetn(resetn),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest), .field_ok_in(field_ok_in),
   .load_mod(load_mod), .tx_active(tx_active));

// ===== verif/reader_model.sv
`timescale 1ns/10ps
module reader_model (
   input  logic        field_on,
   input  logic        load_mod,
   output logic        carrier_in,
   output logic        field_ok_in,
   output logic [15:0] pulses
);
   initial begin
      carrier_in = 0;
      pulses = 0;
      #37;
      forever #100 carrier_in = field_on & ~carrier_in;
   end
   assign field_ok_in = field_on;
   always @(posedge load_mod) pulses <= pulses + 16'h1;
endmodule

// ===== verif/tb.sv
`timescale 1ns/10ps
module tb;
   logic        clk, resetn, read, write, field_on, was_tx;
   logic [4:0]  address;
   logic [31:0] writedata, readdata;
   logic        waitrequest, carrier_in, field_ok_in, load_mod, tx_active;
   logic [15:0] pulses;
   logic [63:0] exp_q[$];
   int          err_count, check_count, seed, k;
   vicinity_tag_response_framer #(.ALLOC_CLASS(8'h5a), .MAKER_CODE(8'h3c),
      .SERIAL_NUM(48'h0123_4567_89ab)) dut (.clk(clk), .resetn(resetn), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .carrier_in(carrier_in), .field_ok_in(field_ok_in),
      .load_mod(load_mod), .tx_active(tx_active));
   reader_model far (.field_on(field_on), .load_mod(load_mod), .carrier_in(carrier_in),
      .field_ok_in(field_ok_in), .pulses(pulses));
   initial begin
      clk = 0;
      forever #12.5 clk = ~clk;
   end
   // ==========
   // Checking and closing
   task automatic test_done;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp(logic [31:0] got, logic [63:0] e);
      check_count++;
      if ((got & e[63:32]) !== e[31:0]) begin
         err_count++;
         $display("Error at %0t got %h exp %h", $time, got, e[31:0]);
      end
   endtask
   // Negative edge sees what the next rising edge will sample
   always @(negedge clk) begin
      if (read && waitrequest === 1'b0) cmp(readdata, exp_q.pop_front());
      if (was_tx === 1'b1 && tx_active === 1'b0) cmp({16'h0, pulses}, exp_q.pop_front());
      was_tx <= tx_active;
   end
   // ==========
   // Bus tasks
   task automatic bus(logic rd, logic [4:0] a, logic [31:0] d, logic [63:0] e);
      if (rd) exp_q.push_back(e);
      read <= rd;
      write <= !rd;
      address <= a;
      writedata <= d;
      do @(posedge clk); while (waitrequest !== 1'b0);
      read <= 0;
      write <= 0;
      @(posedge clk);
   endtask
   task automatic rd(logic [4:0] a, logic [31:0] m, logic [31:0] x);
      bus(1, a, 0, {m, x});
   endtask
   task automatic wr(logic [4:0] a, logic [31:0] d);
      bus(0, a, d, 0);
   endtask
   task automatic req(logic bad);
      logic [15:0] c;
      logic [7:0]  b;
      c = 16'hffff;
      wr(tag_framer_pkg::A_CTRL, 32'h88);
      repeat (2) begin
         b = 8'($random(seed));
         wr(tag_framer_pkg::A_RXD, {24'h0, b});
         c = c ^ {8'h0, b};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
      end
      c = ~c ^ {15'h0, bad};
      wr(tag_framer_pkg::A_RXD, {24'h0, c[7:0]});
      wr(tag_framer_pkg::A_RXD, {24'h0, c[15:8]});
      wr(tag_framer_pkg::A_CTRL, 32'h40);
   endtask
   // Flags byte plus two CRC bytes: 24 bits at a fixed pulse count per bit
   task automatic frame(logic [31:0] cfg, logic [15:0] n, int w);
      req(0);
      rd(tag_framer_pkg::A_CTRL, 32'h30, 32'h10);
      exp_q.push_back({32'hffff, 16'h0, n});
      wr(tag_framer_pkg::A_CTRL, cfg | 32'h10);
      wr(tag_framer_pkg::A_TXD, {24'h0, 8'($random(seed))});
      wr(tag_framer_pkg::A_CTRL, cfg | 32'h20);
      for (k = 0; k < 70000 && tx_active !== 1'b0; k++) begin
         @(posedge clk);
         // Field loss inside the short SOF gap cuts the frame
         if (k == w) field_on <= 0;
      end
      @(posedge clk);
      $display("frame test done");
   endtask
   // ==========
   // Main sequence
   initial begin
      seed = 32'hbf837e16;
      {resetn, read, write, field_on, address, writedata} <= 0;
      repeat (2) @(posedge clk);
      resetn <= 1;
      field_on <= 1;
      repeat (8) @(posedge clk);
      rd(tag_framer_pkg::A_CTRL, 32'h300, 32'h100);
      rd(tag_framer_pkg::A_UIDH, '1, 32'h5a3c0123);
      rd(tag_framer_pkg::A_UIDL, '1, 32'h456789ab);
      rd(5'h02, '1, 32'h0);
      wr(tag_framer_pkg::A_AFC, 32'h1a5);
      wr(tag_framer_pkg::A_AFC, 32'h03c);
      rd(tag_framer_pkg::A_AFC, 32'h1ff, 32'h1a5);
      $display("register test done");
      req(1);
      rd(tag_framer_pkg::A_CTRL, 32'h30, 32'h20);
      wr(tag_framer_pkg::A_CTRL, 32'h12);
      rd(tag_framer_pkg::A_CTRL, 32'h8, 32'h0);
      $display("bad request test done");
      frame(32'h7, 16'd128, 70000);
      frame(32'h2, 16'd152, 13300);
      repeat (8) @(posedge clk);
      rd(tag_framer_pkg::A_CTRL, 32'h300, 32'h0);
      test_done();
   end
   initial begin
      #2_400_000;
      err_count++;
      test_done();
   end
endmodule
